// ==== core/sac_core.sv ====
/*
 * Digital control of a 12-bit successive-approximation converter: four
 * 8-bit registers on AXI4-Lite, channel select, resolution, conversion time,
 * end flag with interrupt request and automatic reference enable.
 * Assumes the analog comparator output is asynchronous to clock_i.
 */
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
module sac_core
  import sac_pkg::*;
#(
  parameter int COEF12   = 52,
  parameter int COEF8    = 32,
  parameter int STEP_LEN = 4
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  // AXI4-Lite write address and data
  input  wire logic              axi_awvalid_i,
  output logic                   axi_awready_o,
  input  wire logic [ADDR_W-1:0] axi_awaddr_i,
  input  wire logic              axi_wvalid_i,
  output logic                   axi_wready_o,
  input  wire logic [31:0]       axi_wdata_i,
  input  wire logic [3:0]        axi_wstrb_i,
  // AXI4-Lite write response
  output logic                   axi_bvalid_o,
  input  wire logic              axi_bready_i,
  output logic [1:0]             axi_bresp_o,
  // AXI4-Lite read
  input  wire logic              axi_arvalid_i,
  output logic                   axi_arready_o,
  input  wire logic [ADDR_W-1:0] axi_araddr_i,
  output logic                   axi_rvalid_o,
  input  wire logic              axi_rready_i,
  output logic [31:0]            axi_rdata_o,
  output logic [1:0]             axi_rresp_o,
  // Analog front end
  input  wire logic              comp_i,
  output logic [3:0]             channel_o,
  output logic [RES_W-1:0]       dac_code_o,
  output logic                   ref_enable_o,
  output logic                   irq_o
);
  // Bus state
  logic              aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [IDX_W-1:0]  aw_idx_q, aw_idx_d;
  logic [7:0]        w_byte_q, w_byte_d;
  logic              w_lane_q, w_lane_d;
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              wr_en;
  logic [IDX_W-1:0]  ar_idx;
  // Converter state
  logic [7:0]        ctrl_q, ctrl_d, mode_q, mode_d, low_q, low_d, high_q, high_d;
  sac_state_t        state_q, state_d;
  logic [RES_W-1:0]  trial_q, trial_d;
  logic [BIT_W-1:0]  bit_q, bit_d;
  logic [7:0]        step_q, step_d;
  logic [TOT_W-1:0]  tot_q, tot_d;
  logic              res8_q, res8_d, dbl_q, dbl_d, ref_q, ref_d, irq_q, irq_d;
  logic [2:0]        sync_q, sync_d;
  logic              comp_q, comp_d;
  logic              start, abort, finish;
  logic [2:0]        tcode;
  int                tot_calc;

  function automatic logic [7:0] read_reg(input logic [IDX_W-1:0] idx,
                                         input logic [7:0] c, m, l, h);
    case (idx)
      IDX_CONTROL:  read_reg = c;
      IDX_MODE:     read_reg = m;
      IDX_RES_LOW:  read_reg = l;
      IDX_RES_HIGH: read_reg = h;
      default:      read_reg = REG_RESET;
    endcase
  endfunction : read_reg

  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    mapped = (idx == IDX_CONTROL) || (idx == IDX_MODE) ||
             (idx == IDX_RES_LOW) || (idx == IDX_RES_HIGH);
  endfunction : mapped

  // Address and data are caught independently; the write happens once both are held
  always_comb begin
    ar_idx    = axi_araddr_i[ADDR_W-1:2];
    aw_held_d = aw_held_q;
    aw_idx_d  = aw_idx_q;
    w_held_d  = w_held_q;
    w_byte_d  = w_byte_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    wr_en     = 1'b0;
    if (axi_awvalid_i && awready_q) begin
      aw_held_d = 1'b1;
      aw_idx_d  = axi_awaddr_i[ADDR_W-1:2];
    end
    if (axi_wvalid_i && wready_q) begin
      w_held_d = 1'b1;
      w_byte_d = axi_wdata_i[7:0];
      w_lane_d = axi_wstrb_i[0];
    end
    if (bvalid_q && axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (aw_held_q && w_held_q && !bvalid_q) begin
      wr_en     = w_lane_q;
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_q && axi_rready_i) begin
      rvalid_d = 1'b0;
    end
    if (axi_arvalid_i && arready_q) begin
      rvalid_d = 1'b1;
      rdata_d  = {24'h00_0000, read_reg(ar_idx, ctrl_q, mode_q, low_q, high_q)};
      rresp_d  = mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_d = !aw_held_d;
    wready_d  = !w_held_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      aw_held_q <= 1'b0;
      aw_idx_q  <= '0;
      w_held_q  <= 1'b0;
      w_byte_q  <= REG_RESET;
      w_lane_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= RDATA_ZERO;
      rresp_q   <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      aw_idx_q  <= aw_idx_d;
      w_held_q  <= w_held_d;
      w_byte_q  <= w_byte_d;
      w_lane_q  <= w_lane_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // Registers, comparator synchroniser and approximation sequencer
  always_comb begin
    ctrl_d   = ctrl_q;
    mode_d   = mode_q;
    low_d    = low_q;
    high_d   = high_q;
    state_d  = state_q;
    trial_d  = trial_q;
    bit_d    = bit_q;
    step_d   = step_q;
    tot_d    = tot_q;
    res8_d   = res8_q;
    dbl_d    = dbl_q;
    start    = 1'b0;
    abort    = 1'b0;
    finish   = 1'b0;
    sync_d   = {sync_q[1:0], comp_i};
    comp_d   = (sync_q[1] == sync_q[2]) ? sync_q[2] : comp_q;
    tcode    = {low_q[LOW_TM], mode_q[MODE_TM_MSB:MODE_TM_LSB]};
    // Ratio 1/2^code stretches the base count by 2^code; rounded up to whole cycles
    tot_calc = (((mode_q[MODE_RES] ? COEF8 : COEF12) << tcode) + TIME_ADD
                + TIME_DIV - 1) / TIME_DIV;
    if (!mode_q[MODE_RES] && dbl_q) begin
      tot_calc = tot_calc * 2;
    end
    if (wr_en) begin
      case (aw_idx_q)
        IDX_CONTROL: begin
          ctrl_d[CH_MSB:CH_LSB] = w_byte_q[CH_MSB:CH_LSB];
          ctrl_d[CTL_FIXED]     = w_byte_q[CTL_FIXED];
          ctrl_d[CTL_IRQ_EN]    = w_byte_q[CTL_IRQ_EN];
          ctrl_d[CTL_DONE]      = ctrl_q[CTL_DONE] & w_byte_q[CTL_DONE];
          start = w_byte_q[CTL_RUN] && (state_q == ST_IDLE);
          abort = !w_byte_q[CTL_RUN] && (state_q != ST_IDLE);
        end
        IDX_MODE: begin
          mode_d = w_byte_q;
          if (mode_q[MODE_RES] && !w_byte_q[MODE_RES]) begin
            dbl_d = 1'b1;
          end
        end
        IDX_RES_LOW:  low_d  = w_byte_q;
        IDX_RES_HIGH: high_d = w_byte_q;
        default: ;
      endcase
    end
    if (start) begin
      ctrl_d[CTL_RUN] = 1'b1;
      state_d = ST_SETTLE;
      trial_d = TRIAL_FIRST;
      bit_d   = BIT_FIRST;
      step_d  = 8'(STEP_LEN - 1);
      tot_d   = TOT_W'(tot_calc);
      res8_d  = mode_q[MODE_RES];
      if (!mode_q[MODE_RES]) begin
        dbl_d = 1'b0;
      end
    end else if (abort) begin
      ctrl_d[CTL_RUN] = 1'b0;
      state_d = ST_IDLE;
    end else begin
      if (state_q != ST_IDLE && tot_q != '0) begin
        tot_d = tot_q - 1'b1;
      end
      case (state_q)
        ST_IDLE: ;
        ST_SETTLE: begin
          if (step_q == 8'h00) begin
            state_d = ST_DECIDE;
          end else begin
            step_d = step_q - 8'h01;
          end
        end
        ST_DECIDE: begin
          // Comparator high means the input sits at or above the trial level
          trial_d[bit_q] = comp_q;
          if (bit_q == (res8_q ? BIT_LAST_8 : BIT_LAST_12)) begin
            state_d = ST_WAIT;
          end else begin
            bit_d            = bit_q - 1'b1;
            trial_d[bit_d]   = 1'b1;
            step_d           = 8'(STEP_LEN - 1);
            state_d          = ST_SETTLE;
          end
        end
        ST_WAIT: begin
          if (tot_q == '0) begin
            finish          = 1'b1;
            state_d         = ST_IDLE;
            ctrl_d[CTL_RUN] = 1'b0;
            ctrl_d[CTL_DONE] = 1'b1;
            high_d = trial_q[RES_W-1:RES_W-8];
            if (!res8_q) begin
              low_d[LOW_RES_MSB:LOW_RES_LSB] = trial_q[3:0];
            end
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
    ref_d = (state_d != ST_IDLE);
    irq_d = ctrl_d[CTL_IRQ_EN] & ctrl_d[CTL_DONE];
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ctrl_q  <= REG_RESET;
      mode_q  <= REG_RESET;
      low_q   <= REG_RESET;
      high_q  <= REG_RESET;
      state_q <= ST_IDLE;
      trial_q <= '0;
      bit_q   <= '0;
      step_q  <= 8'h00;
      tot_q   <= '0;
      res8_q  <= 1'b0;
      dbl_q   <= 1'b1;
      ref_q   <= 1'b0;
      irq_q   <= 1'b0;
      sync_q  <= 3'h0;
      comp_q  <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      mode_q  <= mode_d;
      low_q   <= low_d;
      high_q  <= high_d;
      state_q <= state_d;
      trial_q <= trial_d;
      bit_q   <= bit_d;
      step_q  <= step_d;
      tot_q   <= tot_d;
      res8_q  <= res8_d;
      dbl_q   <= dbl_d;
      ref_q   <= ref_d;
      irq_q   <= irq_d;
      sync_q  <= sync_d;
      comp_q  <= comp_d;
    end
  end

  assign axi_awready_o = awready_q;
  assign axi_wready_o  = wready_q;
  assign axi_bvalid_o  = bvalid_q;
  assign axi_bresp_o   = bresp_q;
  assign axi_arready_o = arready_q;
  assign axi_rvalid_o  = rvalid_q;
  assign axi_rdata_o   = rdata_q;
  assign axi_rresp_o   = rresp_q;
  assign channel_o     = ctrl_q[CH_MSB:CH_LSB];
  assign dac_code_o    = trial_q;
  assign ref_enable_o  = ref_q;
  assign irq_o         = irq_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  sequence seq_start;
    start;
  endsequence
  sequence seq_running;
    ctrl_q[CTL_RUN] && (state_q != ST_IDLE);
  endsequence

  chk_start_runs: assert property (seq_start |=> seq_running ##0 state_q == ST_SETTLE)
    else $error("start did not launch a conversion");
  chk_abort_stops: assert property (abort |=> !ctrl_q[CTL_RUN] && state_q == ST_IDLE
                                    && !$rose(ctrl_q[CTL_DONE]))
    else $error("abort left the conversion running");
  chk_finish_flags: assert property (finish |=> !ctrl_q[CTL_RUN] && ctrl_q[CTL_DONE])
    else $error("completion did not clear run and set done");
  chk_done_sticky: assert property (ctrl_q[CTL_DONE] && !wr_en |=> ctrl_q[CTL_DONE])
    else $error("end flag cleared itself");
  chk_irq_level: assert property (ctrl_q[CTL_DONE] && ctrl_q[CTL_IRQ_EN] |-> irq_o)
    else $error("interrupt request missing");
  chk_ref_busy: assert property (ref_enable_o == (state_q != ST_IDLE))
    else $error("reference enable out of step with conversion");
  chk_low_kept: assert property (finish && res8_q && !(wr_en && aw_idx_q == IDX_RES_LOW)
                                 |=> low_q == $past(low_q))
    else $error("8-bit result disturbed the low byte");
  chk_step_order: assert property (state_q == ST_DECIDE && bit_q != BIT_LAST_12
                                   && !res8_q && !abort |=> bit_q == $past(bit_q) - 1'b1
                                   ##0 state_q == ST_SETTLE)
    else $error("approximation step order broken");
endmodule : sac_core

// ==== core/sac_pkg.sv ====
/*
 * Shared constants for the successive-approximation converter control block:
 * register indices, field positions, reset values, bus codes and states.
 * Assumes a 32-bit AXI4-Lite register bus with byte address = 4 x index.
 */
package sac_pkg;
  localparam int          IDX_W         = 16;
  localparam int          ADDR_W        = IDX_W + 2;
  localparam int          RES_W         = 12;
  localparam int          TOT_W         = 14;
  localparam int          BIT_W         = 4;
  // Register indices (byte address is four times the index)
  localparam logic [15:0] IDX_CONTROL   = 16'hfe58;
  localparam logic [15:0] IDX_MODE      = 16'hfe59;
  localparam logic [15:0] IDX_RES_LOW   = 16'hfe5a;
  localparam logic [15:0] IDX_RES_HIGH  = 16'hfe5b;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  // Control register fields
  localparam int          CH_MSB        = 7;
  localparam int          CH_LSB        = 4;
  localparam int          CTL_FIXED     = 3;
  localparam int          CTL_RUN       = 2;
  localparam int          CTL_DONE      = 1;
  localparam int          CTL_IRQ_EN    = 0;
  // Mode register fields
  localparam int          MODE_RES      = 6;
  localparam int          MODE_TM_MSB   = 1;
  localparam int          MODE_TM_LSB   = 0;
  // Result low byte fields
  localparam int          LOW_TM        = 0;
  localparam int          LOW_RES_MSB   = 7;
  localparam int          LOW_RES_LSB   = 4;
  // Approximation constants
  localparam logic [11:0] TRIAL_FIRST   = 12'h800;
  localparam logic [3:0]  BIT_FIRST     = 4'hb;
  localparam logic [3:0]  BIT_LAST_12   = 4'h0;
  localparam logic [3:0]  BIT_LAST_8    = 4'h4;
  localparam int          TIME_ADD      = 2;
  localparam int          TIME_DIV      = 3;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_SETTLE = 2'h1,
    ST_DECIDE = 2'h3,
    ST_WAIT   = 2'h2
  } sac_state_t;
endpackage : sac_pkg

// ==== testbench/sac_front_model.sv ====
/*
 * Behavioural analog front end: per-channel input levels and a comparator.
 * Assumes the trial code holds still through each settle window.
 */
`timescale 1ns/1ps
module sac_front_model (
  // Clock
  input  wire logic        clock_i,
  // From the control block
  input  wire logic [3:0]  channel_i,
  input  wire logic [11:0] dac_code_i,
  input  wire logic        ref_enable_i,
  // To the control block
  output logic             comp_o
);
  logic [11:0] level;
  logic        idle_q = 1'b0;

  // Each selected channel shows its own fixed level
  assign level = 12'h0a5 + 12'(channel_i) * 12'h151;
  // Ladder off gives no real decision, so nothing steady is offered
  always @(posedge clock_i) idle_q <= ~idle_q;
  assign comp_o = ref_enable_i ? (level >= dac_code_i) : idle_q;
endmodule : sac_front_model

// ==== testbench/sar_adc_control_tb.sv ====
/*
 * Self-checking bench: register bus master, conversion rows, then interrupt,
 * abort, unmapped access and mid-run reset cases.
 * Assumes the front-end model in sac_front_model.
 */
`timescale 1ns/1ps
module sar_adc_control_tb
  import sac_pkg::*;
();
  localparam int STEP = 4;
  localparam int LIM  = 40000;
  typedef struct {
    logic [3:0] ch;
    logic       res8;
    logic [2:0] code;
    logic [7:0] hi;
    logic [7:0] lo;
  } sac_row_t;
  logic              clock_i, srst_i, awvalid, wvalid, bready, arvalid, rready, comp;
  logic              awready, wready, bvalid, arready, rvalid, ref_en, irq, dbl, prev8;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, d;
  logic [3:0]        wstrb, chan;
  logic [1:0]        bresp, rresp, s;
  logic [11:0]       dac;
  int                miscompares, checked;
  int                busy_n = 0;
  // Channel, 8-bit mode, time code, expected high and low byte
  sac_row_t rows [12] = '{
    '{4'h0, 1'b0, 3'h0, 8'h0a, 8'h50}, '{4'h1, 1'b1, 3'h1, 8'h1f, 8'ha0},
    '{4'h2, 1'b0, 3'h2, 8'h34, 8'h70}, '{4'h3, 1'b1, 3'h3, 8'h49, 8'ha0},
    '{4'h4, 1'b0, 3'h4, 8'h5e, 8'h91}, '{4'h5, 1'b1, 3'h5, 8'h73, 8'ha1},
    '{4'h6, 1'b0, 3'h6, 8'h88, 8'hb1}, '{4'h7, 1'b1, 3'h7, 8'h9d, 8'ha1},
    '{4'h8, 1'b0, 3'h0, 8'hb2, 8'hd0}, '{4'h9, 1'b1, 3'h1, 8'hc7, 8'ha0},
    '{4'ha, 1'b0, 3'h2, 8'hdc, 8'hf0}, '{4'hb, 1'b1, 3'h3, 8'hf2, 8'ha0}};

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  sac_core #(.COEF12(52), .COEF8(32), .STEP_LEN(STEP)) uut (
    .clock_i(clock_i), .srst_i(srst_i),
    .axi_awvalid_i(awvalid), .axi_awready_o(awready), .axi_awaddr_i(awaddr),
    .axi_wvalid_i(wvalid), .axi_wready_o(wready), .axi_wdata_i(wdata),
    .axi_wstrb_i(wstrb), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
    .axi_bresp_o(bresp), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
    .axi_araddr_i(araddr), .axi_rvalid_o(rvalid), .axi_rready_i(rready),
    .axi_rdata_o(rdata), .axi_rresp_o(rresp), .comp_i(comp), .channel_o(chan),
    .dac_code_o(dac), .ref_enable_o(ref_en), .irq_o(irq));

  sac_front_model fe (.clock_i(clock_i), .channel_i(chan), .dac_code_i(dac),
    .ref_enable_i(ref_en), .comp_o(comp));

  // Length of the reference-on window measures the conversion time
  always @(posedge clock_i) if (ref_en) busy_n <= busy_n + 1;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [15:0] idx, input logic [7:0] v, output logic [1:0] r);
    logic a, w;
    a = 1'b1;
    w = 1'b1;
    @(posedge clock_i);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'h0, v};
    do begin
      @(posedge clock_i);
      if (a && awready) awvalid <= 1'b0;
      if (a && awready) a = 1'b0;
      if (w && wready) wvalid <= 1'b0;
      if (w && wready) w = 1'b0;
    end while (a || w);
    do @(posedge clock_i); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] idx, output logic [31:0] v, output logic [1:0] r);
    @(posedge clock_i);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    araddr  <= {idx, 2'b00};
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock_i); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rchk(input string nm, input logic [15:0] idx, input logic [7:0] e);
    logic [31:0] v;
    logic [1:0]  r;
    rd(idx, v, r);
    chk(nm, v, {24'h0, e});
  endtask : rchk

  task automatic wait_idle;
    repeat (2) @(posedge clock_i);
    do @(posedge clock_i); while (ref_en);
  endtask : wait_idle

  task automatic run_row(input sac_row_t r);
    int e, b0;
    // Expected time: ceil((K * 2^code + 2) / 3), doubled for a 12-bit row after reset or an 8-bit row, floored by the steps
    e = (((r.res8 ? 32 : 52) << r.code) + 4) / 3;
    if (prev8 && !r.res8) dbl = 1'b1;
    if (!r.res8 && dbl) e = 2 * e;
    if (!r.res8) dbl = 1'b0;
    prev8 = r.res8;
    if (e < (r.res8 ? 8 : 12) * (STEP + 1)) e = (r.res8 ? 8 : 12) * (STEP + 1);
    wr(IDX_MODE, {1'b0, r.res8, 4'h0, r.code[1:0]}, s);
    wr(IDX_RES_LOW, {4'ha, 3'h0, r.code[2]}, s);
    // The counter belongs to its own process; only its value at the start is noted here
    b0 = busy_n;
    wr(IDX_CONTROL, {r.ch, 4'h4}, s);
    chk("channel", chan, r.ch);
    wait_idle();
    chk("conv_time", busy_n - b0 >= e - 1 && busy_n - b0 <= e + 3, 1);
    rchk("control", IDX_CONTROL, {r.ch, 4'h2});
    rchk("result_high", IDX_RES_HIGH, r.hi);
    rchk("result_low", IDX_RES_LOW, r.lo);
    wr(IDX_CONTROL, {r.ch, 4'h0}, s);
  endtask : run_row

  task automatic end_of_test;
    $display("checked %0d, miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (LIM) @(posedge clock_i);
    miscompares++;
    end_of_test();
  end

  initial begin
    srst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    {miscompares, checked} = '0;
    dbl = 1'b1;
    prev8 = 1'b0;
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rchk("reset_value", IDX_CONTROL + 16'(i), REG_RESET);
    foreach (rows[i]) run_row(rows[i]);
    // Done flag with interrupt enable: sticky until software clears it
    wr(IDX_CONTROL, 8'h05, s);
    wait_idle();
    repeat (20) @(posedge clock_i);
    chk("irq", irq, 1'b1);
    rchk("control", IDX_CONTROL, 8'h03);
    wr(IDX_CONTROL, 8'h01, s);
    repeat (2) @(posedge clock_i);
    chk("irq", irq, 1'b0);
    rchk("control", IDX_CONTROL, 8'h01);
    // Abort a 12-bit conversion in mid-run
    wr(IDX_MODE, 8'h03, s);
    wr(IDX_CONTROL, 8'h74, s);
    repeat (10) @(posedge clock_i);
    chk("ref_on", ref_en, 1'b1);
    wr(IDX_CONTROL, 8'h70, s);
    repeat (2) @(posedge clock_i);
    chk("ref_off", ref_en, 1'b0);
    rchk("control", IDX_CONTROL, 8'h70);
    rchk("result_high", IDX_RES_HIGH, 8'h0a);
    // A write with byte lane 0 disabled is answered but changes nothing
    wstrb <= 4'h0;
    wr(IDX_RES_HIGH, 8'h55, s);
    wstrb <= 4'hf;
    chk("bresp", s, RESP_OKAY);
    rchk("result_high", IDX_RES_HIGH, 8'h0a);
    // Unmapped places answer with an error and read as zero
    wr(16'hfe5c, 8'hff, s);
    chk("bresp", s, RESP_SLVERR);
    rd(16'h0100, d, s);
    chk("rresp", s, RESP_SLVERR);
    chk("rdata", d, RDATA_ZERO);
    // Reset during a conversion
    wr(IDX_CONTROL, 8'h94, s);
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    @(posedge clock_i);
    chk("ref_after_reset", ref_en, 1'b0);
    for (int i = 0; i < 4; i++) rchk("reset_value", IDX_CONTROL + 16'(i), REG_RESET);
    end_of_test();
  end
endmodule : sar_adc_control_tb
